// file: hdl/aiac_top.sv
// Purpose: analog input acquisition control: channel mask, sources, sample clock and burst trigger
// Assumes: rate ticks, output trigger request and buffer empty come from logic on core_clk
// Notes:   registers on a simple host port, read answer one cycle after the strobe
//
// Behaviour
// R01 - sample all active channels together
// R02 - sixteen enable bits, reset ones, upper zero
// R03 - disabled channels write nothing to buffer
// R04 - source field steers inputs, test disconnects system
// R05 - range A and B per channel group
// R06 - master takes clocks from generator or strobe
// R07 - software sample strobe always gives one clock; code takes no sample with it while burst enabled and not busy
// R08 - master drives clock pin low pulses
// R09 - target clocks on pin falling edges
// R10 - clock master bit resets low
// R11 - burst disabled means continuous sampling
// R12 - trigger starts burst, stops at count
// R13 - 24-bit burst length per channel
// R14 - zero length burst never ends alone
// R15 - last value of burst gets tag
// R16 - busy flag high exactly during burst
// R17 - triggers ignored unless armed
// R18 - trigger master uses generator or strobe
// R19 - software burst strobe always gives trigger
// R20 - trigger master pulses pin per trigger
// R21 - trigger target uses pin falling edges
// R22 - target edge fires enabled trigger paths
// R23 - source code encoding of six modes
// R24 - software strobes clear themselves
// R25 - clock master bit at position 24
// R26 - pin inputs synchronised before edge detect
`timescale 1ns/1ns
module aiac_top
  import aiac_pkg::*;
#(
  parameter int NCH = `AIAC_NCH
)(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // host register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  // rate generators, output side and buffer
  input  wire logic        rate_a_tick,
  input  wire logic        rate_b_tick,
  input  wire logic        out_trig_req,
  input  wire logic        out_trig_en,
  input  wire logic        buf_empty,
  // shared sample clock pin
  input  wire logic        smp_clk_i,
  output logic             smp_clk_o,
  output logic             smp_clk_oe,
  // shared trigger pin
  input  wire logic        trig_i,
  output logic             trig_o,
  output logic             trig_oe,
  // converters and input switching
  output logic             conv_strobe,
  output logic      [15:0] conv_mask,
  output logic      [2:0]  src_sel,
  output logic             sys_connect,
  output logic      [31:0] ch_range,
  output logic             offset_binary,
  // input buffer
  output logic             buf_wr,
  output logic      [3:0]  buf_chan,
  output logic             buf_first,
  output logic             buf_last,
  output logic             buf_clear,
  // other events
  output logic             out_trig_fire,
  output logic             burst_busy
);
  if (NCH != `AIAC_NCH) begin : g_chk
    $error("aiac_top: only sixteen channels are supported");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state and helpers
  aiac_top_s q, d;          // state and next state
  aiac_if    wk ();         // carrier to the channel walker
  logic      clk_fall;      // synchronised falling edge on clock pin
  logic      trig_fall;     // synchronised falling edge on trigger pin
  logic      smp_ev;        // sample clock from any source
  logic      in_trig;       // input burst trigger from any source
  logic      armed;         // burst armed, trigger may start one
  logic      smp_take;      // sample clock accepted
  logic      set_last;      // accepted sample closes the burst
  logic      clk_off;       // sample clock source disabled
  logic      trig_pin_fire; // pulse request for trigger pin
  logic [23:0] cnt_nx;      // burst count after this sample

  ////////////////////////////////////////////////////////////////////////////////
  // event decoding
  always_comb
  begin
    // software strobe or selected hardware source
    smp_ev = q.board_control_word[`AIAC_SWCLK]                                               // [R07]
           | (q.board_control_word[`AIAC_CLK_MST] ? (rate_a_tick & q.board_control_word[`AIAC_RATEA_EN])  // [R06]
                                   : clk_fall);                              // [R09]
    in_trig = q.board_control_word[`AIAC_SWTRIG]                                            // [R19]
            | (q.board_control_word[`AIAC_TRIG_MST] ? (rate_b_tick & q.board_control_word[`AIAC_RATEB_EN]) // [R18]
                                     : trig_fall);                           // [R21] [R22]
    armed         = q.board_control_word[`AIAC_BURST_EN] & !q.busy;                         // [R17]
    smp_take      = smp_ev & (!q.board_control_word[`AIAC_BURST_EN] | q.busy);              // [R11] [R12]
    cnt_nx        = q.cnt + 24'h000001;
    set_last      = q.busy & (q.blen != 24'h000000) & (cnt_nx == q.blen);    // [R13]
    clk_off       = q.board_control_word[`AIAC_CLK_MST] & !q.board_control_word[`AIAC_RATEA_EN];
    trig_pin_fire = in_trig | out_trig_req;                                  // [R20]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    d               = q;
    d.rvalid        = 1'b0;
    d.conv_strobe   = 1'b0;
    d.out_trig_fire = 1'b0;
    d.buf_clear     = 1'b0;
    // self clearing strobes last one cycle
    d.board_control_word[`AIAC_SWCLK]   = 1'b0;                                           // [R24]
    d.board_control_word[`AIAC_SWTRIG]  = 1'b0;                                           // [R24]
    d.board_control_word[`AIAC_BUF_CLR] = 1'b0;
    d.buf_clear          = q.board_control_word[`AIAC_BUF_CLR];
    // sample clock: all active channels at once
    if (smp_take)
    begin
      d.conv_strobe = 1'b1;                                                // [R01]
      d.conv_mask   = q.mask;
    end
    // burst control
    if (armed && in_trig)
    begin
      d.busy = 1'b1;                                                       // [R12] [R16]
      d.cnt  = 24'h000000;
    end
    else if (q.busy)
    begin
      if (!q.board_control_word[`AIAC_BURST_EN])
      begin
        d.busy = 1'b0;                                                     // [R16]
      end
      else if (smp_take)
      begin
        d.cnt = cnt_nx;
        if (set_last)
        begin
          d.busy = 1'b0;                                                   // [R12]
        end
      end
      else if (q.blen == 24'h000000 && (clk_off || buf_empty))
      begin
        d.busy = 1'b0;                                                     // [R14]
      end
    end
    // target trigger edge also feeds the output side when enabled
    d.out_trig_fire = !q.board_control_word[`AIAC_TRIG_MST] & trig_fall & out_trig_en;     // [R22]
    // input switching and ranges follow the control word
    d.src_sel     = q.board_control_word[`AIAC_SRC_HI:`AIAC_SRC_LO];                      // [R23]
    d.sys_connect = (q.board_control_word[`AIAC_SRC_HI:`AIAC_SRC_LO] == `AIAC_SRC_DIFF)
                  | (q.board_control_word[`AIAC_SRC_HI:`AIAC_SRC_LO] == `AIAC_SRC_SE);    // [R04]
    for (int c = 0; c < `AIAC_NCH; c++)
    begin
      // channels with bit 1 of their number set use range B
      if (c[1])
      begin
        d.ch_range[2*c +: 2] = q.board_control_word[`AIAC_RNGB_HI:`AIAC_RNGB_LO];         // [R05]
      end
      else
      begin
        d.ch_range[2*c +: 2] = q.board_control_word[`AIAC_RNGA_HI:`AIAC_RNGA_LO];         // [R05]
      end
    end
    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        `AIAC_OFF_BCR:
        begin
          d.board_control_word = reg_wdata & `AIAC_BCR_WMASK;
        end
        `AIAC_OFF_MASK:
        begin
          d.mask = reg_wdata[15:0];                                        // [R02]
        end
        `AIAC_OFF_BLEN:
        begin
          d.blen = reg_wdata[23:0];                                        // [R13]
        end
        default:
        begin
          d.rvalid = 1'b0;                                                 // unmapped, ignored
        end
      endcase
    end
    // register reads answer next cycle
    if (reg_rd)
    begin
      d.rvalid = 1'b1;
      unique case (reg_addr)
        `AIAC_OFF_BCR:
        begin
          d.rdata              = q.board_control_word;
          d.rdata[`AIAC_BUSY]  = q.busy;                                   // [R16]
        end
        `AIAC_OFF_MASK:
        begin
          d.rdata = {16'h0000, q.mask};                                    // [R02]
        end
        `AIAC_OFF_BLEN:
        begin
          d.rdata = {8'h00, q.blen};
        end
        default:
        begin
          d.rdata = 32'h00000000;                                          // unmapped reads zero
        end
      endcase
    end
    // initialize restores every default
    if (q.board_control_word[`AIAC_INIT])
    begin
      d.board_control_word  = `AIAC_BCR_RST;
      d.mask = `AIAC_MASK_RST;
      d.blen = `AIAC_BLEN_RST;
      d.busy = 1'b0;
      d.cnt  = 24'h000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '{board_control_word: `AIAC_BCR_RST, mask: `AIAC_MASK_RST, blen: `AIAC_BLEN_RST,      // [R10] [R02]
             cnt: 24'h000000, busy: 1'b0, rdata: 32'h00000000, rvalid: 1'b0,
             conv_strobe: 1'b0, conv_mask: 16'h0000, ch_range: 32'haaaaaaaa,
             src_sel: `AIAC_SRC_DIFF, sys_connect: 1'b1, out_trig_fire: 1'b0, buf_clear: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins
  aiac_pin u_clk_pin (
    .core_clk (core_clk),
    .rst      (rst),
    .master   (q.board_control_word[`AIAC_CLK_MST]),
    .fire     (smp_ev),
    .pin_i    (smp_clk_i),
    .pin_o    (smp_clk_o),
    .pin_oe   (smp_clk_oe),
    .fall     (clk_fall)
  );
  aiac_pin u_trig_pin (
    .core_clk (core_clk),
    .rst      (rst),
    .master   (q.board_control_word[`AIAC_TRIG_MST]),
    .fire     (trig_pin_fire),
    .pin_i    (trig_i),
    .pin_o    (trig_o),
    .pin_oe   (trig_oe),
    .fall     (trig_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // channel walker: one buffer write per active channel
  assign wk.start    = smp_take & q.board_control_word[`AIAC_BUF_EN];                    // [R03]
  assign wk.mask     = q.mask;
  assign wk.last_set = set_last;                                           // [R15]
  aiac_seq u_seq (
    .core_clk (core_clk),
    .rst      (rst),
    .bus      (wk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata     = q.rdata;
  assign reg_rvalid    = q.rvalid;
  assign conv_strobe   = q.conv_strobe;
  assign conv_mask     = q.conv_mask;
  assign src_sel       = q.src_sel;
  assign sys_connect   = q.sys_connect;
  assign ch_range      = q.ch_range;
  assign offset_binary = q.board_control_word[`AIAC_OFFBIN];
  assign buf_wr        = wk.wr;
  assign buf_chan      = wk.chan;
  assign buf_first     = wk.first;
  assign buf_last      = wk.last;
  assign buf_clear     = q.buf_clear;
  assign out_trig_fire = q.out_trig_fire;
  assign burst_busy    = q.busy;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence sw_clk_write_s;
    reg_wr && reg_addr == `AIAC_OFF_BCR && reg_wdata[`AIAC_SWCLK] && !reg_wdata[`AIAC_INIT] && !q.board_control_word[`AIAC_INIT];
  endsequence
  sequence strobe_out_s;
    q.board_control_word[`AIAC_SWCLK] ##1 !q.board_control_word[`AIAC_SWCLK];
  endsequence
  mask_upper_zero_a: assert property (reg_rd && reg_addr == `AIAC_OFF_MASK |=> reg_rdata[31:16] == 16'h0000)
    else $error("mask upper bits not zero"); // [R02]
  sw_clock_once_a: assert property (sw_clk_write_s |=> strobe_out_s
                                    ##0 (conv_strobe || $past(q.board_control_word[`AIAC_BURST_EN] && !q.busy)))
    else $error("software clock lost"); // [R07] [R24]
  target_ignores_rate_a: assert property (!q.board_control_word[`AIAC_CLK_MST] && !q.board_control_word[`AIAC_SWCLK] && !clk_fall |=> !conv_strobe)
    else $error("target clocked without edge"); // [R09]
  continuous_sample_a: assert property (smp_ev && !q.board_control_word[`AIAC_BURST_EN] |=> conv_strobe && conv_mask == $past(q.mask))
    else $error("continuous sample missing"); // [R11] [R01]
  unarmed_ignore_a: assert property (in_trig && !armed && !q.busy && !q.board_control_word[`AIAC_INIT] |=> !burst_busy)
    else $error("trigger taken while unarmed"); // [R17]
  burst_end_a: assert property (q.busy && smp_take && set_last && !q.board_control_word[`AIAC_INIT] |=> !burst_busy)
    else $error("burst did not stop at count"); // [R12]
  busy_needs_en_a: assert property (q.busy && !q.board_control_word[`AIAC_BURST_EN] |=> !burst_busy)
    else $error("busy without burst enable"); // [R16]
  source_connect_a: assert property (##1 sys_connect == ($past(q.board_control_word[`AIAC_SRC_HI:`AIAC_SRC_LO]) < `AIAC_SRC_ZERO))
    else $error("system inputs not steered"); // [R04]
  range_group_a: assert property (##1 ch_range[3:2] == $past(q.board_control_word[`AIAC_RNGA_HI:`AIAC_RNGA_LO])
                                  && ch_range[5:4] == $past(q.board_control_word[`AIAC_RNGB_HI:`AIAC_RNGB_LO]))
    else $error("range group wrong"); // [R05]
  zero_len_runs_a: assert property (q.busy && q.blen == 24'h000000 && q.board_control_word[`AIAC_BURST_EN] && !clk_off
                                    && !buf_empty && !q.board_control_word[`AIAC_INIT] |=> burst_busy)
    else $error("endless burst stopped"); // [R14]
endmodule

// file: include/aiac_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the acquisition control block
// Assumes: byte offsets on the host register port, 32-bit words
// Notes:   definitions only
`ifndef AIAC_MAP_SVH
`define AIAC_MAP_SVH
// register offsets
`define AIAC_OFF_BCR      8'h00
`define AIAC_OFF_MASK     8'h14
`define AIAC_OFF_BLEN     8'h1c
// board control word fields
`define AIAC_SRC_HI       2
`define AIAC_SRC_LO       0
`define AIAC_RNGA_HI      5
`define AIAC_RNGA_LO      4
`define AIAC_RNGB_HI      7
`define AIAC_RNGB_LO      6
`define AIAC_SWCLK        8
`define AIAC_BURST_EN     9
`define AIAC_BUSY         10
`define AIAC_SWTRIG       11
`define AIAC_BUF_EN       12
`define AIAC_BUF_CLR      13
`define AIAC_TRIG_MST     21
`define AIAC_CLK_MST      24
`define AIAC_OFFBIN       25
`define AIAC_RATEA_EN     26
`define AIAC_RATEB_EN     27
`define AIAC_INIT         31
// reset values and writable bits
`define AIAC_BCR_RST      32'h020000a0
`define AIAC_BCR_WMASK    32'h8f203ff7
`define AIAC_MASK_RST     16'hffff
`define AIAC_BLEN_RST     24'h000400
// input source codes
`define AIAC_SRC_DIFF     3'h0
`define AIAC_SRC_SE       3'h1
`define AIAC_SRC_ZERO     3'h2
`define AIAC_SRC_VREF     3'h3
`define AIAC_SRC_OUT0     3'h4
`define AIAC_SRC_OUT1     3'h5
// pin pulse timing
`define AIAC_CLK_NS       4
`define AIAC_PULSE_NS     40
`define AIAC_PULSE_CYC    ((`AIAC_PULSE_NS + `AIAC_CLK_NS - 1) / `AIAC_CLK_NS)
`define AIAC_NCH          16
`endif

// file: include/aiac_pkg.sv
// Purpose: types of the acquisition control block
// Assumes: aiac_map.svh for widths
// Notes:   one state struct per module
`include "aiac_map.svh"
package aiac_pkg;
  // channel walker states
  typedef enum logic [0:0] {AIAC_IDLE, AIAC_WALK} aiac_seq_e;
  typedef struct packed {
    logic [31:0] board_control_word;        // stored control word
    logic [15:0] mask;       // channel enables
    logic [23:0] blen;       // samples per channel per burst
    logic [23:0] cnt;        // samples taken in current burst
    logic        busy;       // burst in progress
    logic [31:0] rdata;      // read answer
    logic        rvalid;     // read answer valid
    logic        conv_strobe;
    logic [15:0] conv_mask;
    logic [31:0] ch_range;
    logic [2:0]  src_sel;
    logic        sys_connect;
    logic        out_trig_fire;
    logic        buf_clear;
  } aiac_top_s;
  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [7:0] cnt;
    logic       pin_o;
    logic       pin_oe;
    logic       fall;
  } aiac_pin_s;
  typedef struct packed {
    aiac_seq_e   st;
    logic [15:0] left;
    logic        last_set;
    logic        first;
    logic        wr;
    logic [3:0]  chan;
    logic        tag_first;
    logic        tag_last;
  } aiac_seq_s;
endpackage

// file: include/aiac_if.sv
// Purpose: carrier between the control core and the channel walker
// Assumes: single clock
// Notes:   ctl starts a set, seq reports buffer writes
`timescale 1ns/1ns
interface aiac_if;
  logic        start;      // accepted sample clock, buffer enabled
  logic [15:0] mask;       // active channels of this set
  logic        last_set;   // this set closes a burst
  logic        wr;         // buffer write pulse
  logic [3:0]  chan;       // channel written
  logic        first;      // lowest active channel of set
  logic        last;       // last value of burst
  modport ctl (output start, mask, last_set, input wr, chan, first, last);
  modport seq (input start, mask, last_set, output wr, chan, first, last);
endinterface

// file: hdl/aiac_pin.sv
// Purpose: shared clock or trigger pin: synchroniser, falling edge, low pulse driver
// Assumes: pin_i is asynchronous to core_clk
// Notes:   edges are only looked for while the pin is an input
`timescale 1ns/1ns
module aiac_pin
  import aiac_pkg::*;
#(
  parameter int PULSE_CYC = `AIAC_PULSE_CYC
)(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic master,
  input  wire logic fire,
  // pin
  input  wire logic pin_i,
  output logic      pin_o,
  output logic      pin_oe,
  // event
  output logic      fall
);
  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_chk
    $error("aiac_pin: PULSE_CYC out of range");
  end
  aiac_pin_s q, d;   // state and next state
  // next state
  always_comb
  begin
    d        = q;
    d.sync1  = pin_i;
    d.sync2  = q.sync1;
    d.prev   = q.sync2;
    d.pin_oe = master;                                     // [R25] [R10]
    d.fall   = !master && q.prev && !q.sync2;             // [R26] [R09] [R21]
    if (!master)
    begin
      d.cnt = 8'h00;
    end
    else if (fire)
    begin
      d.cnt = 8'(PULSE_CYC);                               // [R08] [R20]
    end
    else if (q.cnt != 8'h00)
    begin
      d.cnt = q.cnt - 8'h01;
    end
    d.pin_o = !(master && (fire || d.cnt > 8'h01));
  end
  // registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, cnt: 8'h00, pin_o: 1'b1, pin_oe: 1'b0, fall: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end
  assign pin_o  = q.pin_o;
  assign pin_oe = q.pin_oe;
  assign fall   = q.fall;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  oe_follows_a: assert property (##1 pin_oe == $past(master)) else $error("pin enable wrong"); // [R25]
  edge_once_a: assert property (fall |=> !fall) else $error("double edge event");           // [R26]
  fire_low_a: assert property (master && fire |=> !pin_o || !master) else $error("no pulse"); // [R08]
endmodule

// file: hdl/aiac_seq.sv
// Purpose: walks the active channels of one sample set into buffer writes
// Assumes: sets arrive no faster than one per channel count plus one cycles
// Notes:   a start during a walk is dropped
`timescale 1ns/1ns
module aiac_seq
  import aiac_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // carrier
  aiac_if.seq       bus
);
  aiac_seq_s q, d;   // state and next state
  // lowest set bit of a channel vector
  function automatic logic [3:0] low_bit(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction
  // next state
  always_comb
  begin
    d    = q;
    d.wr = 1'b0;
    // tags are pulses that travel with their write, never left standing
    d.tag_first = 1'b0;
    d.tag_last  = 1'b0;
    unique case (q.st)
      AIAC_IDLE:
      begin
        if (bus.start && bus.mask != 16'h0000)
        begin
          d.st       = AIAC_WALK;
          d.left     = bus.mask;      // [R03]
          d.last_set = bus.last_set;
          d.first    = 1'b1;
        end
      end
      AIAC_WALK:
      begin
        d.wr        = 1'b1;
        d.chan      = low_bit(q.left);
        d.tag_first = q.first;
        d.left      = q.left & ~(16'h0001 << d.chan);
        d.tag_last  = q.last_set && d.left == 16'h0000; // [R15]
        d.first     = 1'b0;
        if (d.left == 16'h0000)
        begin
          d.st = AIAC_IDLE;
        end
      end
    endcase
  end
  // registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '{st: AIAC_IDLE, left: 16'h0000, last_set: 1'b0, first: 1'b0, wr: 1'b0,
             chan: 4'h0, tag_first: 1'b0, tag_last: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end
  assign bus.wr    = q.wr;
  assign bus.chan  = q.chan;
  assign bus.first = q.tag_first;
  assign bus.last  = q.tag_last;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  last_only_end_a: assert property (bus.last |-> bus.wr && q.st == AIAC_IDLE) else $error("tag mid set"); // [R15]
  wr_in_walk_a: assert property (bus.wr |-> $past(q.st) == AIAC_WALK) else $error("stray write"); // [R03]
endmodule

// file: verif/aiac_peer.sv
// Purpose: peer board on the shared clock and trigger pins
// Assumes: a released pin reads high through its pull-up
// Notes:   drives a pin low only while told to
`timescale 1ns/1ns
module aiac_peer_model (
  // pin drive, high when released
  output logic clk_drv,
  output logic trig_drv
);
  initial {clk_drv, trig_drv} = 2'b11;
  // one falling edge, held past the two sync stages, then release
  task automatic fall(input bit t);
    if (t) trig_drv = 1'b0;
    else clk_drv = 1'b0;
    #8 {clk_drv, trig_drv} = 2'b11;
  endtask
endmodule

// file: verif/aiac_tb.sv
// Purpose: self-checking bench of the acquisition control block
// Assumes: peer model on both shared pins
// Notes:   rate generator B and output trigger request held idle, rate generator A ticked once
`timescale 1ns/1ns
`include "aiac_map.svh"
module analog_input_acquisition_control_tb_top;
  import aiac_pkg::*;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, ch_range, board_control_word, d, e;
  logic reg_rvalid, smp_clk_o, smp_clk_oe, trig_o, trig_oe, conv_strobe, sys_connect;
  logic offset_binary, buf_wr, buf_first, buf_last, buf_clear, out_trig_fire, burst_busy;
  logic [15:0] conv_mask, msk, st = 16'hcc69;
  logic [2:0] src_sel;
  logic [3:0] buf_chan;
  logic clk_drv, trig_drv, rate_a_tick = 0, out_trig_en = 0, buf_empty = 0;
  int n_errors = 0, samples_checked = 0, nw = 0, nl = 0, k, p, i, c, k0, l0;
  aiac_peer_model peer (.clk_drv(clk_drv), .trig_drv(trig_drv));
  aiac_top u_aiac_top (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rate_a_tick(rate_a_tick), .rate_b_tick(1'b0), .out_trig_req(1'b0), .out_trig_en(out_trig_en),
    .buf_empty(buf_empty), .smp_clk_i(smp_clk_oe ? smp_clk_o : clk_drv), .smp_clk_o(smp_clk_o),
    .smp_clk_oe(smp_clk_oe), .trig_i(trig_oe ? trig_o : trig_drv), .trig_o(trig_o),
    .trig_oe(trig_oe), .conv_strobe(conv_strobe), .conv_mask(conv_mask), .src_sel(src_sel),
    .sys_connect(sys_connect), .ch_range(ch_range), .offset_binary(offset_binary),
    .buf_wr(buf_wr), .buf_chan(buf_chan), .buf_first(buf_first), .buf_last(buf_last),
    .buf_clear(buf_clear), .out_trig_fire(out_trig_fire), .burst_busy(burst_busy));
  always #2 core_clk = ~core_clk;
  // model: count buffer writes and burst tags
  always @(posedge core_clk)
    if (buf_wr === 1'b1)
    begin
      nw <= nw + 1;
      nl <= nl + (buf_last === 1'b1);
      ck({buf_first, conv_mask[buf_chan]}, {(conv_mask & ((16'h1 << buf_chan) - 16'h1)) == 16'h0, 1'b1});
    end
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x)
    begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    @(posedge core_clk) #1 reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk) #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge core_clk) #1 reg_rd = 0;
    ck(reg_rvalid, 1);
    d = reg_rdata;
  endtask
  // bounded wait: 0 busy high, 1 busy low, 2 sample strobe, 3 driven low clock pin
  task automatic wt(input int s);
    for (k = 0; k < 60; k++)
    begin
      if (s == 0 && burst_busy === 1 || s == 1 && burst_busy === 0 || s == 2 && conv_strobe === 1
          || s == 3 && smp_clk_o === 0 && smp_clk_oe === 1) break;
      @(posedge core_clk) #1;
    end
    ck(k < 60, 1);
    if (k == 60) close_out();
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1 rst = 0;
    board_control_word = 32'h020000a0;
    rd(`AIAC_OFF_BCR); ck(d, board_control_word);
    ck({smp_clk_oe, trig_oe, offset_binary}, 3'b001);
    rd(`AIAC_OFF_MASK); ck(d, 32'h0000ffff);
    ck(ch_range, 32'haaaaaaaa);
    // every source code with independent ranges
    for (i = 0; i < 6; i++)
    begin
      wr(`AIAC_OFF_BCR, board_control_word & ~32'hff | i | (i % 3) << 4 | (2 - i % 3) << 6);
      #8;
      for (c = 0; c < 16; c++) e[2*c +: 2] = c[1] ? 2 - i % 3 : i % 3;
      ck(src_sel, i);
      ck(sys_connect, i < 2);
      ck(ch_range, e);
    end
    board_control_word |= 32'h1000;
    // random masks, sampled by strobe or peer clock edge
    for (i = 0; i < 3; i++)
    begin
      st = lf(st);
      msk = st;
      wr(`AIAC_OFF_MASK, {16'hffff, msk});
      rd(`AIAC_OFF_MASK); ck(d, {16'h0, msk});
      p = $countones(msk);
      k0 = nw;
      if (i == 2) peer.fall(0);
      else wr(`AIAC_OFF_BCR, board_control_word | 32'h900);
      wt(2); ck(conv_mask, msk);
      ck(burst_busy, 0);
      repeat (20) @(posedge core_clk);
      ck(nw - k0, p);
    end
    board_control_word |= 32'h05000000;
    wr(`AIAC_OFF_BCR, board_control_word | 32'h100);
    wt(3);
    repeat (20) @(posedge core_clk);
    // one rate generator tick in clock master mode
    @(posedge core_clk) #1 rate_a_tick = 1;
    @(posedge core_clk) #1 rate_a_tick = 0;
    wt(2); ck(conv_mask, msk);
    repeat (20) @(posedge core_clk);
    // burst of two sets started from the peer trigger
    wr(`AIAC_OFF_BLEN, 32'h2);
    board_control_word |= 32'h200;
    k0 = nw;
    l0 = nl;
    wr(`AIAC_OFF_BCR, board_control_word | 32'h100);
    repeat (20) @(posedge core_clk);
    ck(nw - k0, 0);
    out_trig_en = 1;
    peer.fall(1);
    wt(0);
    ck(out_trig_fire, 1);
    for (i = 0; i < 2; i++)
    begin
      wr(`AIAC_OFF_BCR, board_control_word | 32'h100);
      repeat (20) @(posedge core_clk);
    end
    wt(1);
    ck(nw - k0, 2 * p);
    ck(nl - l0, 1);
    // endless burst from the software trigger as trigger master, ended by an empty buffer
    wr(`AIAC_OFF_BLEN, 32'h0);
    board_control_word |= 32'h200000;
    wr(`AIAC_OFF_BCR, board_control_word | 32'h800);
    wt(0); ck({trig_o, trig_oe}, 2'b01);
    repeat (20) @(posedge core_clk);
    #1 buf_empty = 1;
    ck(burst_busy, 1);
    wt(1);
    // initialize restores the defaults
    wr(`AIAC_OFF_BCR, 32'h80000000);
    rd(`AIAC_OFF_BCR); ck(d, 32'h020000a0);
    rd(`AIAC_OFF_MASK); ck(d, 32'h0000ffff);
    close_out();
  end
endmodule
